// >>> logic/ipl_levels.sv
// axi4-lite register block holding 2-bit priority levels for lines 0 to 11
//
// Contract
// - group0 at 0x400, lines 0-3, resets zero
// - group1 at 0x404, lines 4-7, resets zero
// - group2 at 0x408, lines 8-11, resets zero
// - level 0 most urgent, 3 least urgent
// - all three registers readable and writable
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ipl_levels (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [23:0] line_levels,
  output logic [3:0] urgent_line,
  output logic [1:0] urgent_level
);

  // all state in one struct
  typedef struct packed {
    logic [2:0][31:0] group;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] urg_line;
    logic [1:0] urg_level;
  } ipl_state_t;

  ipl_state_t st_ff; // registered state
  ipl_state_t nxt_st; // next state

  // map a byte address to a group index, 3 when unmapped
  function automatic logic [1:0] ipl_decode(input logic [11:0] addr);
    unique case (addr)
      ipl_pkg::LEVEL_GROUP0_OFS: ipl_decode = 2'h0;
      ipl_pkg::LEVEL_GROUP1_OFS: ipl_decode = 2'h1;
      ipl_pkg::LEVEL_GROUP2_OFS: ipl_decode = 2'h2;
      default: ipl_decode = 2'h3;
    endcase
  endfunction : ipl_decode

  // next-state logic: bus slave, register update and urgency search
  always_comb begin
    logic [1:0] widx;
    logic [1:0] ridx;
    logic [31:0] bmask;
    logic [1:0] lvl;
    nxt_st = st_ff;
    widx = ipl_decode(st_ff.aw_addr);
    ridx = ipl_decode(s_axi_araddr);
    bmask = '0;
    lvl = 2'h0;
    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    // both halves held: commit and respond
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      for (int b = 0; b < 4; b++) begin
        bmask[b*8 +: 8] = {8{st_ff.w_strb[b]}};
      end
      if (widx != 2'h3) begin
        // only the field bits take the write, the gaps stay zero
        nxt_st.group[widx] = (st_ff.group[widx] & ~(bmask & ipl_pkg::LEVEL_FIELD_MASK)) |
          (st_ff.w_data & bmask & ipl_pkg::LEVEL_FIELD_MASK);
        nxt_st.bresp = ipl_pkg::RESP_OKAY;
      end else begin
        nxt_st.bresp = ipl_pkg::RESP_SLVERR;
      end
      nxt_st.bvalid = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
    end
    // response accepted
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read: answer one cycle after address taken
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      if (ridx != 2'h3) begin
        nxt_st.rdata = st_ff.group[ridx] & ipl_pkg::LEVEL_FIELD_MASK;
        nxt_st.rresp = ipl_pkg::RESP_OKAY;
      end else begin
        nxt_st.rdata = 32'h00000000;
        nxt_st.rresp = ipl_pkg::RESP_SLVERR;
      end
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // lowest level value wins, lower line number breaks ties
    // start from the least urgent level so a block with every line at 3 still names line 0
    nxt_st.urg_line = 4'h0;
    nxt_st.urg_level = 2'h3;
    for (int i = ipl_pkg::LINE_COUNT - 1; i >= 0; i--) begin
      lvl = st_ff.group[i / ipl_pkg::LINES_PER_GROUP][(i % ipl_pkg::LINES_PER_GROUP) * ipl_pkg::FIELD_STRIDE
        + ipl_pkg::FIELD_LSB +: ipl_pkg::LEVEL_WIDTH];
      if (lvl <= nxt_st.urg_level) begin
        nxt_st.urg_level = lvl;
        nxt_st.urg_line = 4'(i);
      end
    end
  end

  // state register with synchronous reset and clock enable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      for (int g = 0; g < ipl_pkg::GROUP_COUNT; g++) begin
        st_ff.group[g] <= ipl_pkg::LEVEL_GROUP_RESET;
      end
      // search result agrees with the all-zero reset levels: line 0 at level 0
      st_ff.urg_level <= ipl_pkg::LEVEL_GROUP_RESET[ipl_pkg::FIELD_LSB +: ipl_pkg::LEVEL_WIDTH];
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // handshake outputs
  // readies fall while frozen so nothing is taken that the frozen state cannot hold
  assign s_axi_awready = clk_en && !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = clk_en && !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = clk_en && !st_ff.rvalid;
  // registered answers
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign urgent_line = st_ff.urg_line;
  assign urgent_level = st_ff.urg_level;

  // level of each line, line k at bits [2k+1:2k]
  always_comb begin
    for (int i = 0; i < ipl_pkg::LINE_COUNT; i++) begin
      line_levels[i*2 +: 2] = st_ff.group[i / ipl_pkg::LINES_PER_GROUP][(i % ipl_pkg::LINES_PER_GROUP)
        * ipl_pkg::FIELD_STRIDE + ipl_pkg::FIELD_LSB +: ipl_pkg::LEVEL_WIDTH];
    end
  end

  // checks
  // gap bits never hold a one in any group
  gap_bits_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((st_ff.group[0] | st_ff.group[1] | st_ff.group[2]) & ~ipl_pkg::LEVEL_FIELD_MASK) == 32'h0)
    else $error("gap bits of a level register are not zero");
  group0_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && st_ff.aw_addr == ipl_pkg::LEVEL_GROUP0_OFS
    && st_ff.w_strb == 4'hf |=> line_levels[7:0] == {$past(st_ff.w_data[31:30]), $past(st_ff.w_data[23:22]),
    $past(st_ff.w_data[15:14]), $past(st_ff.w_data[7:6])})
    else $error("group0 write did not reach lines 0 to 3");
  group1_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    line_levels[15:14] == st_ff.group[1][31:30] && line_levels[9:8] == st_ff.group[1][7:6])
    else $error("group1 fields misplaced");
  group2_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    line_levels[23:22] == st_ff.group[2][31:30] && line_levels[17:16] == st_ff.group[2][7:6])
    else $error("group2 fields misplaced");
  urgent_min_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> urgent_level <= $past(line_levels[1:0]) && urgent_level <= $past(line_levels[23:22]))
    else $error("urgent level is not the minimum");
  read_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ipl_pkg::LEVEL_GROUP1_OFS
    |=> s_axi_rvalid && s_axi_rdata == $past(st_ff.group[1]))
    else $error("read back differs from stored value");
  resp_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  write_answer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  // a write with a byte lane switched off leaves that lane's line alone
  lane_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && st_ff.aw_addr == ipl_pkg::LEVEL_GROUP1_OFS
    && !st_ff.w_strb[0] |=> line_levels[9:8] == $past(line_levels[9:8]))
    else $error("unstrobed lane of group1 was written");
  // a write to an unmapped offset changes no level
  unmapped_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && st_ff.aw_addr != ipl_pkg::LEVEL_GROUP0_OFS
    && st_ff.aw_addr != ipl_pkg::LEVEL_GROUP1_OFS && st_ff.aw_addr != ipl_pkg::LEVEL_GROUP2_OFS
    |=> line_levels == $past(line_levels))
    else $error("unmapped write changed a level");
  // reset clears every level and the search result
  reset_zero_a: assert property (@(posedge core_clk)
    !rst_n |=> line_levels == 24'h0 && urgent_level == 2'h0)
    else $error("levels not cleared by reset");
  // main scenarios: full and partial writes, reads, a winning line, a freeze
  write_done_c: cover property (@(posedge core_clk) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
  read_done_c: cover property (@(posedge core_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
  urgent_zero_c: cover property (@(posedge core_clk) disable iff (!rst_n) urgent_level == 2'h0 && urgent_line == 4'hb);
  strobe_write_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_wvalid && s_axi_wready && s_axi_wstrb != 4'hf);
  frozen_c: cover property (@(posedge core_clk) disable iff (!rst_n) !clk_en);
endmodule : ipl_levels

// >>> logic/ipl_pkg.sv
// package of offsets, field layout and reset values for the priority-level block
package ipl_pkg;
  // register byte offsets from the system control space base
  localparam logic [11:0] LEVEL_GROUP0_OFS = 12'h400;
  localparam logic [11:0] LEVEL_GROUP1_OFS = 12'h404;
  localparam logic [11:0] LEVEL_GROUP2_OFS = 12'h408;
  // number of lines and registers
  localparam int LINE_COUNT = 12;
  localparam int LINES_PER_GROUP = 4;
  localparam int GROUP_COUNT = 3;
  // field geometry: line k of a group sits at bits [8k+7 : 8k+6]
  localparam int LEVEL_WIDTH = 2;
  localparam int FIELD_STRIDE = 8;
  localparam int FIELD_LSB = 6;
  // mask of the writable bits of one group register
  localparam logic [31:0] LEVEL_FIELD_MASK = 32'hc0c0c0c0;
  // reset value of every group register
  localparam logic [31:0] LEVEL_GROUP_RESET = 32'h00000000;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ipl_pkg

// >>> verification/ipl_axi_master.sv
// axi4-lite master model standing in for processor software
`timescale 1ns/1ps
module ipl_axi_master (
  input wire logic core_clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // write responses are always accepted at once; read ready may lag to hold an answer up
  assign bready = 1'b1;
  // idle request lines at time zero
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, arvalid} = '0;
    wstrb = 4'hf;
    rready = 1'b1;
  end
  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r, output logic ok,
    input logic [3:0] s = 4'hf);
    ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) {r, ok} = {bresp, 1'b1};
    end
  endtask : wr
  // read: address held until taken, data taken when rvalid and rready are both high
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok,
    input logic slow = 1'b0);
    ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) {d, r, ok} = {rdata, rresp, 1'b1};
      else if (rvalid) rready <= 1'b1;
    end
  endtask : rd
endmodule : ipl_axi_master

// >>> verification/ipl_levels_tb.sv
// self-checking bench for the priority-level register block
`timescale 1ns/1ps
module ipl_levels_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] aa, ra;
  logic [31:0] wd, rd, got;
  logic [3:0] ws, ul;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ok;
  logic [1:0] bre, rre, ulv, resp;
  logic [23:0] lv;
  logic [31:0] sh [3];
  int mismatches = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;
  ipl_levels dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .line_levels(lv), .urgent_line(ul), .urgent_level(ulv));
  ipl_axi_master m (.core_clk(core_clk), .awaddr(aa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
    .wvalid(wv), .wready(wr), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ra), .arvalid(arv),
    .arready(arr), .rdata(rd), .rresp(rre), .rvalid(rv), .rready(rr));
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // counts, verdict, end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // a bus wait that ran out ends the run
  task automatic hang();
    if (!ok) begin
      mismatches++;
      test_done();
    end
  endtask : hang
  // level outputs after settling one cycle, from the shadow copy
  task automatic outs(input logic [3:0] eln, input logic [1:0] elv);
    logic [23:0] ex;
    @(posedge core_clk);
    for (int k = 0; k < 12; k++) ex[2*k+:2] = sh[k/4][8*(k%4)+6+:2];
    chk("line_levels", 32'(ex), 32'(lv));
    chk("urgent", {26'h0, eln, elv}, {26'h0, ul, ulv});
  endtask : outs
  // write one group with byte strobes, check response and read-back
  task automatic put(input int g, input logic [31:0] d, input logic [3:0] eln, input logic [1:0] elv,
    input logic [3:0] s = 4'hf);
    m.wr(ipl_pkg::LEVEL_GROUP0_OFS + 12'(4*g), d, resp, ok, s);
    hang();
    chk("bresp", 32'(ipl_pkg::RESP_OKAY), 32'(resp));
    for (int b = 0; b < 4; b++) begin
      if (s[b]) sh[g][8*b +: 8] = d[8*b +: 8] & 8'hc0;
    end
    m.rd(ipl_pkg::LEVEL_GROUP0_OFS + 12'(4*g), got, resp, ok);
    hang();
    chk("rdata", sh[g], got);
    outs(eln, elv);
  endtask : put
  // all groups read back zero after a reset, line 0 at level 0 wins
  task automatic rst_chk();
    sh = '{3{32'h0}};
    for (int g = 0; g < 3; g++) begin
      m.rd(ipl_pkg::LEVEL_GROUP0_OFS + 12'(4*g), got, resp, ok);
      hang();
      chk("reset", 32'h0, got);
    end
    outs(4'h0, 2'h0);
  endtask : rst_chk
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rst_chk();
    $display("test reset done");
    put(0, 32'hffffffff, 4'd4, 2'h0);
    put(1, 32'hffffffff, 4'd8, 2'h0);
    put(2, 32'hffffffff, 4'd0, 2'h3);
    put(2, 32'hc0c040c0, 4'd9, 2'h1);
    put(1, 32'h40c0c0c0, 4'd7, 2'h1);
    put(0, 32'hc0c0c03f, 4'd0, 2'h0);
    put(0, 32'h80c0c0c0, 4'd7, 2'h1);
    $display("test levels done");
    m.wr(12'h40c, 32'hffffffff, resp, ok);
    hang();
    chk("bresp", 32'(ipl_pkg::RESP_SLVERR), 32'(resp));
    m.rd(12'h40c, got, resp, ok, 1'b1);
    hang();
    chk("rdata", 32'h0, got);
    chk("rresp", 32'(ipl_pkg::RESP_SLVERR), 32'(resp));
    outs(4'd7, 2'h1);
    $display("test unmapped done");
    put(1, 32'h00000000, 4'd7, 2'h0, 4'h8);
    $display("test strobes done");
    clk_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("frozen ready", 32'h0, {29'h0, awr, wr, arr});
    outs(4'd7, 2'h0);
    clk_en <= 1'b1;
    $display("test freeze done");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rst_chk();
    $display("test second reset done");
    test_done();
  end
endmodule : ipl_levels_tb
